// file: bench/partial_reconfig_delivery_properties.sv
// Checker watching the link between the controller and the config engine.
// Assumes the bench instantiates it beside cfg_link_if, one clock domain.
`timescale 1ns/1ps
module partial_reconfig_delivery_properties (
  // Clock and reset.
  input wire logic                        clk,
  input wire logic                        rst_b,
  // Link signals.
  input wire logic                        word_valid,
  input wire logic                        word_ready,
  input wire logic [31:0]                 word_data,
  input wire cfg_delivery_pkg::port_sel_t port_sel,
  input wire logic                        pins_persist,
  input wire logic                        reset_after_reconfig,
  input wire logic                        config_done_flag,
  input wire logic                        user_mode,
  input wire logic                        load_error
);
  import cfg_delivery_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  logic        taken;
  logic        desync_taken;
  logic [31:0] last_hdr_ff;
  logic [31:0] nxt_last_hdr;

  assign taken        = word_valid && word_ready;
  assign desync_taken = taken && word_data == DESYNC_WORD;

  // Remembers the header of the stream now or last delivered.
  always_comb begin
    nxt_last_hdr = last_hdr_ff;
    if (taken && (word_data == HDR_PARTIAL || word_data == HDR_CLEAR ||
                  word_data == HDR_BLANK || word_data == HDR_FULL)) begin
      nxt_last_hdr = word_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_hdr_ff <= 32'h00000000;
    end else begin
      last_hdr_ff <= nxt_last_hdr;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_refuse_master;
    port_sel == PORT_MASTER |-> !word_ready;
  endproperty
  a_refuse_master: assert property (p_refuse_master)
    else $error("word accepted on a master port");

  property p_refuse_persist;
    port_sel == PORT_INTERNAL && pins_persist |-> !word_ready;
  endproperty
  a_refuse_persist: assert property (p_refuse_persist)
    else $error("internal port accepted while pins persist");

  property p_done_after_desync;
    $rose(config_done_flag) |-> $past(desync_taken, 2);
  endproperty
  a_done_after_desync: assert property (p_done_after_desync)
    else $error("done rose without a desync two cycles before");

  property p_user_with_done;
    $rose(user_mode) |-> $rose(config_done_flag);
  endproperty
  a_user_with_done: assert property (p_user_with_done)
    else $error("user mode entered without done");

  property p_user_holds;
    user_mode |=> user_mode;
  endproperty
  a_user_holds: assert property (p_user_holds)
    else $error("user mode left during operation");

  property p_check_stall;
    taken && word_data == DESYNC_WORD |=> !word_ready;
  endproperty
  a_check_stall: assert property (p_check_stall)
    else $error("words accepted right after desync");

  property p_done_drops;
    taken && user_mode && reset_after_reconfig &&
      (word_data == HDR_PARTIAL || word_data == HDR_CLEAR)
      |=> !config_done_flag;
  endproperty
  a_done_drops: assert property (p_done_drops)
    else $error("done stayed high at reconfiguration start");

  property p_no_rise_after_clear;
    $rose(config_done_flag) |-> last_hdr_ff != HDR_CLEAR;
  endproperty
  a_no_rise_after_clear: assert property (p_no_rise_after_clear)
    else $error("done rose at the end of a clearing stream");

  property p_error_blocks_done;
    load_error && !user_mode |-> !config_done_flag;
  endproperty
  a_error_blocks_done: assert property (p_error_blocks_done)
    else $error("done high after a corrupt full stream");

  property p_hold_word;
    word_valid && !word_ready |=> word_valid && $stable(word_data);
  endproperty
  a_hold_word: assert property (p_hold_word)
    else $error("word changed while waiting");
endmodule

// file: bench/partial_reconfig_delivery_tb.sv
// Bench joining the reconfiguration controller and the config engine.
// Assumes the design files under rtl/ are compiled first.
`timescale 1ns/1ps
module partial_reconfig_delivery_tb;
  import cfg_delivery_pkg::*;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wr_en = 1'b0;
  logic [3:0]  wr_addr = 4'h0;
  logic [31:0] wr_data = 32'h00000000;
  logic        start = 1'b0;
  logic [3:0]  wcnt = 4'h0;
  logic [1:0]  region = 2'h0;
  logic [3:0]  module_id = 4'h0;
  port_sel_t   port_choice = PORT_JTAG;
  logic        persist = 1'b0;
  logic        rst_after = 1'b0;
  logic        gsr_req = 1'b0;
  logic [7:0]  tieoff_one = 8'h00;
  logic        busy, sent_desync, gsr_pulse, desync_seen;
  logic [3:0]  loaded_module, mask_open, clk_en, blanked, init, rdy;
  logic [3:0]  init_seen, blank_seen, mask_seen;
  logic [7:0]  blank_outputs;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cycles = 0;

  // ----------------------------------------------------------------------
  // Design and checker
  // ----------------------------------------------------------------------
  cfg_link_if i_cfg_link_if (.clk(clk));
  cfg_engine #(.REGIONS(4), .NEED_CLEAR(1'b1)) i_cfg_engine (
    .clk(clk), .rst_b(rst_b), .link(i_cfg_link_if), .gsr_req(gsr_req),
    .tieoff_one(tieoff_one), .region_mask_open(mask_open),
    .region_clk_en(clk_en), .region_blanked(blanked), .region_init(init),
    .region_ready(rdy), .blank_outputs(blank_outputs), .gsr_pulse(gsr_pulse));
  cfg_controller #(.DEPTH(16), .ADDR_W(4)) i_cfg_controller (
    .clk(clk), .rst_b(rst_b), .link(i_cfg_link_if), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .start(start),
    .start_addr(4'h0), .word_count(wcnt), .region(region),
    .module_id(module_id), .port_choice(port_choice), .persist(persist),
    .rst_after(rst_after), .busy(busy), .sent_desync(sent_desync),
    .loaded_module(loaded_module));
  partial_reconfig_delivery_properties i_props (
    .clk(clk), .rst_b(rst_b), .word_valid(i_cfg_link_if.word_valid),
    .word_ready(i_cfg_link_if.word_ready),
    .word_data(i_cfg_link_if.word_data), .port_sel(i_cfg_link_if.port_sel),
    .pins_persist(i_cfg_link_if.pins_persist),
    .reset_after_reconfig(i_cfg_link_if.reset_after_reconfig),
    .config_done_flag(i_cfg_link_if.config_done_flag),
    .user_mode(i_cfg_link_if.user_mode),
    .load_error(i_cfg_link_if.load_error));

  // ----------------------------------------------------------------------
  // Clock, monitors and helpers
  // ----------------------------------------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end

  // Latches pulses seen during one run; cleared by the start pulse.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    init_seen <= start ? 4'h0 : init_seen | init;
    blank_seen <= start ? 4'h0 : blank_seen | blanked;
    mask_seen <= start ? 4'h0 : mask_seen | mask_open;
    desync_seen <= start ? 1'b0 : desync_seen | sent_desync;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    step(2);
    rst_b = 1'b1;
  endtask

  // Stores one stream, with a bad check word if asked, and starts it.
  task automatic load(logic [31:0] hdr, logic bad);
    logic [31:0] w [6];
    int          n;
    w = '{hdr, {30'h0, region}, 32'h12345678, NOOP_WORD, 32'h30000BAD,
          DESYNC_WORD};
    n = 0;
    for (int i = 0; i < 6; i++) begin
      if (i != 4 || bad) begin
        wr_en = 1'b1;
        wr_addr = n[3:0];
        wr_data = w[i];
        step();
        n++;
      end
    end
    wr_en = 1'b0;
    wcnt = n[3:0];
    start = 1'b1;
    step();
    start = 1'b0;
  endtask

  task automatic send(logic [31:0] hdr, logic bad);
    load(hdr, bad);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) step();
    step(3);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_refuse(port_sel_t p, logic per);
    port_choice = p;
    persist = per;
    load(HDR_FULL, 1'b0);
    step(8);
    cmp(i_cfg_link_if.word_ready, 1'b0);
    cmp(busy, 1'b1);
    do_reset();
    port_choice = PORT_JTAG;
    persist = 1'b0;
  endtask

  task automatic t_full();
    send(HDR_FULL, 1'b1);
    cmp(i_cfg_link_if.config_done_flag, 1'b0);
    cmp(i_cfg_link_if.user_mode, 1'b0);
    cmp(i_cfg_link_if.load_error, 1'b1);
    do_reset();
    gsr_req = 1'b1;
    step(2);
    cmp(gsr_pulse, 1'b1);
    gsr_req = 1'b0;
    send(HDR_FULL, 1'b0);
    cmp(i_cfg_link_if.config_done_flag, 1'b1);
    cmp(i_cfg_link_if.user_mode, 1'b1);
    cmp(mask_open, 4'h0);
    gsr_req = 1'b1;
    step(3);
    cmp(gsr_pulse, 1'b0);
    gsr_req = 1'b0;
  endtask

  task automatic t_switch();
    rst_after = 1'b1;
    region = 2'h1;
    module_id = 4'h2;
    port_choice = PORT_PARALLEL;
    send(HDR_CLEAR, 1'b0);
    cmp(i_cfg_link_if.config_done_flag, 1'b0);
    cmp(clk_en[1], 1'b0);
    cmp(mask_seen, 4'h2);
    module_id = 4'h3;
    port_choice = PORT_INTERNAL;
    send(HDR_PARTIAL, 1'b0);
    cmp(i_cfg_link_if.config_done_flag, 1'b1);
    cmp(init_seen, 4'h2);
    cmp(rdy[1], 1'b1);
    cmp(blank_seen[1], 1'b1);
    cmp(desync_seen, 1'b1);
    cmp(loaded_module, 4'h3);
    cmp(i_cfg_link_if.user_mode, 1'b1);
    rst_after = 1'b0;
  endtask

  task automatic t_no_clear();
    region = 2'h2;
    port_choice = PORT_PCIE;
    send(HDR_PARTIAL, 1'b0);
    cmp(init_seen, 4'h0);
    cmp(mask_seen, 4'h4);
    port_choice = PORT_PROC;
    send(HDR_PARTIAL, 1'b1);
    cmp(i_cfg_link_if.load_error, 1'b1);
    cmp(i_cfg_link_if.user_mode, 1'b1);
  endtask

  task automatic t_blank();
    region = 2'h3;
    port_choice = PORT_SERIAL;
    tieoff_one = 8'h5A;
    send(HDR_BLANK, 1'b0);
    cmp(blanked[3], 1'b1);
    cmp(rdy[3], 1'b0);
    cmp(blank_outputs, 8'h5A);
    tieoff_one = 8'h00;
    step();
    cmp(blank_outputs, 8'h00);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    step(20);
    rst_b = 1'b1;
    t_refuse(PORT_MASTER, 1'b0);
    t_refuse(PORT_INTERNAL, 1'b1);
    t_full();
    t_switch();
    t_no_clear();
    t_blank();
    conclude();
  end
endmodule

// file: rtl/cfg_controller.sv
// Reconfiguration controller: streams stored words to the engine.
// Assumes a word memory loaded by the user port, one clock.
`timescale 1ns/1ps
module cfg_controller #(
  parameter int unsigned DEPTH  = 256,
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic                                 clk,
  input  wire logic                                 rst_b,
  // Link to the engine.
  cfg_link_if.controller                            link,
  // User side.
  input  wire logic                                 wr_en,
  input  wire logic [ADDR_W-1:0]                    wr_addr,
  input  wire logic [31:0]                          wr_data,
  input  wire logic                                 start,
  input  wire logic [ADDR_W-1:0]                    start_addr,
  input  wire logic [ADDR_W-1:0]                    word_count,
  input  wire logic [cfg_delivery_pkg::REGION_W-1:0] region,
  input  wire logic [cfg_delivery_pkg::MODULE_W-1:0] module_id,
  input  wire cfg_delivery_pkg::port_sel_t          port_choice,
  input  wire logic                                 persist,
  input  wire logic                                 rst_after,
  output logic                                      busy,
  output logic                                      sent_desync,
  output logic      [cfg_delivery_pkg::MODULE_W-1:0] loaded_module
);
  import cfg_delivery_pkg::*;

  // ----------------------------------------------------------------
  // Word store and streaming.
  // ----------------------------------------------------------------
  logic [31:0]         mem [DEPTH];
  logic                busy_ff,  nxt_busy;
  logic [ADDR_W-1:0]   addr_ff,  nxt_addr;
  logic [ADDR_W-1:0]   left_ff,  nxt_left;
  logic                sent_ff,  nxt_sent;
  logic [MODULE_W-1:0] mods_ff [NUM_REGIONS];
  logic [REGION_W-1:0] reg_ff,   nxt_reg;
  logic [MODULE_W-1:0] mod_ff,   nxt_mod;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_comb begin
    nxt_busy = busy_ff;
    nxt_addr = addr_ff;
    nxt_left = left_ff;
    nxt_sent = 1'b0;
    nxt_reg  = reg_ff;
    nxt_mod  = mod_ff;
    if (!busy_ff && start && word_count != '0) begin
      nxt_busy = 1'b1;
      nxt_addr = start_addr;
      nxt_left = word_count;
      nxt_reg  = region;
      nxt_mod  = module_id;
    end else if (busy_ff && link.word_ready) begin
      nxt_addr = addr_ff + 1'b1; // RULE22
      nxt_left = left_ff - 1'b1;
      if (left_ff == 1) begin
        nxt_busy = 1'b0;
        nxt_sent = mem[addr_ff] == DESYNC_WORD; // RULE11 RULE13
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
      addr_ff <= '0;
      left_ff <= '0;
      sent_ff <= 1'b0;
      reg_ff  <= '0;
      mod_ff  <= '0;
      for (int i = 0; i < NUM_REGIONS; i++) begin
        mods_ff[i] <= '0;
      end
    end else begin
      busy_ff <= nxt_busy;
      addr_ff <= nxt_addr;
      left_ff <= nxt_left;
      sent_ff <= nxt_sent;
      reg_ff  <= nxt_reg;
      mod_ff  <= nxt_mod;
      if (nxt_sent) begin
        mods_ff[reg_ff] <= mod_ff; // RULE21 RULE18
      end
    end
  end

  // Clearing and partial streams go back to back only when stored in one run.
  assign link.word_valid           = busy_ff; // RULE19
  assign link.word_data            = mem[addr_ff];
  assign link.port_sel             = port_choice; // RULE7
  assign link.pins_persist         = persist;
  assign link.reset_after_reconfig = rst_after;
  assign busy                      = busy_ff;
  assign sent_desync               = sent_ff;
  assign loaded_module             = mods_ff[region];

endmodule

// file: rtl/cfg_delivery_pkg.sv
// Shared constants and types for the configuration delivery link.
// Assumes both ends run on one clock and meet in cfg_link_if.
package cfg_delivery_pkg;

  localparam int unsigned WORD_W         = 32;
  localparam int unsigned NUM_REGIONS    = 4;
  localparam int unsigned REGION_W       = 2;
  localparam int unsigned MODULE_W       = 4;
  localparam int unsigned TIEOFF_W       = 8;

  localparam logic [31:0] DESYNC_WORD    = 32'h0000000D;
  localparam logic [31:0] NOOP_WORD      = 32'h20000000;
  localparam logic [31:0] HDR_FULL       = 32'hAA995566;
  localparam logic [31:0] HDR_PARTIAL    = 32'hAA99A001;
  localparam logic [31:0] HDR_CLEAR      = 32'hAA99C001;
  localparam logic [31:0] HDR_BLANK      = 32'hAA99B001;
  localparam logic [31:0] CRC_MARK       = 32'h30000001;

  localparam int unsigned CRC_MARK_POS   = 28;
  localparam int unsigned REGION_LSB     = 0;

  localparam logic [31:0] CRC_SEED       = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY       = 32'h04C11DB7;

  localparam logic        MASK_RESET     = 1'b0;

  typedef enum logic [2:0] {
    PORT_JTAG     = 3'h0,
    PORT_SERIAL   = 3'h1,
    PORT_PARALLEL = 3'h2,
    PORT_INTERNAL = 3'h3,
    PORT_PROC     = 3'h4,
    PORT_PCIE     = 3'h5,
    PORT_MASTER   = 3'h6
  } port_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_HEAD   = 3'b001,
    ST_DATA   = 3'b011,
    ST_CHECK  = 3'b010,
    ST_USER   = 3'b110,
    ST_FAIL   = 3'b111
  } eng_state_t;

  typedef enum logic [1:0] {
    KIND_FULL    = 2'h0,
    KIND_PARTIAL = 2'h1,
    KIND_CLEAR   = 2'h2,
    KIND_BLANK   = 2'h3
  } stream_kind_t;

  // Running checksum over one word, used only by the engine.
  function automatic logic [31:0] crc_step(input logic [31:0] crc,
                                           input logic [31:0] word);
    logic [31:0] c;
    c = crc;
    for (int i = 31; i >= 0; i--) begin
      if (c[31] ^ word[i]) begin
        c = {c[30:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[30:0], 1'b0};
      end
    end
    return c;
  endfunction

endpackage

// file: rtl/cfg_engine.sv
// Configuration engine: takes full, partial, clearing and blanking streams.
// Assumes words arrive in order over cfg_link_if on a single clock.
//
// Notes on behaviour
// RULE1: Mask stays closed; streams open own region.
// RULE2: No chip-wide set/reset after initial configuration.
// RULE3: Corrupt full stream: no done, no user mode.
// RULE4: Verified full stream enters user mode.
// RULE5: Partial loads accepted in user mode; others run.
// RULE6: Per-frame checks and region initialization on partial.
// RULE7: Only non-master ports deliver partial streams.
// RULE8: Partial streams carry no startup; optional CRC checks.
// RULE9: Done low during reconfig, high on success.
// RULE10: Clear plus partial keep done low throughout.
// RULE11: Without reset option, controller watches words itself.
// RULE12: Desync word ends the delivered stream.
// RULE13: Controller releases region after desync sent.
// RULE14: Blanked region outputs zero unless tieoff selects one.
// RULE15: Partial loads blank region during the load.
// RULE16: Clearing opens mask, stops region clocks.
// RULE17: Partial without preceding clear leaves module uninitialized.
// RULE18: Controller sends old module clear before new partial; the controller streams stored words only, no clear of its own.
// RULE19: Controller follows clear with partial promptly; the controller streams one stored run per start only.
// RULE20: Persisted pins disable internal port.
// RULE21: Controller records loaded module per region.
// RULE22: Controller sends words in stored order.
`timescale 1ns/1ps
module cfg_engine #(
  parameter int unsigned REGIONS   = cfg_delivery_pkg::NUM_REGIONS,
  parameter logic        NEED_CLEAR = 1'b1
) (
  // Clock and reset.
  input  wire logic                                 clk,
  input  wire logic                                 rst_b,
  // Link to the controller.
  cfg_link_if.engine                                link,
  // Chip-wide set/reset request from the fabric.
  input  wire logic                                 gsr_req,
  // Region view.
  input  wire logic [cfg_delivery_pkg::TIEOFF_W-1:0] tieoff_one,
  output logic      [REGIONS-1:0]                   region_mask_open,
  output logic      [REGIONS-1:0]                   region_clk_en,
  output logic      [REGIONS-1:0]                   region_blanked,
  output logic      [REGIONS-1:0]                   region_init,
  output logic      [REGIONS-1:0]                   region_ready,
  output logic      [cfg_delivery_pkg::TIEOFF_W-1:0] blank_outputs,
  output logic                                      gsr_pulse
);
  import cfg_delivery_pkg::*;

  // ----------------------------------------------------------------
  // Stream state.
  // ----------------------------------------------------------------
  eng_state_t          state_ff,  nxt_state;
  stream_kind_t        kind_ff,   nxt_kind;
  logic [31:0]         crc_ff,    nxt_crc;
  logic                user_ff,   nxt_user;
  logic                done_ff,   nxt_done;
  logic                err_ff,    nxt_err;
  logic [REGIONS-1:0]  mask_ff,   nxt_mask;
  logic [REGIONS-1:0]  clken_ff,  nxt_clken;
  logic [REGIONS-1:0]  blank_ff,  nxt_blank;
  logic [REGIONS-1:0]  cleared_ff, nxt_cleared;
  logic [REGIONS-1:0]  init_ff,   nxt_init;
  logic [REGIONS-1:0]  gray_ff,   nxt_gray;
  logic [REGION_W-1:0] reg_ff,    nxt_reg;
  logic                gsr_ff,    nxt_gsr;
  logic                port_ok;
  logic                take;
  logic [REGION_W-1:0] w_reg;

  always_comb begin
    port_ok = (link.port_sel != PORT_MASTER); // RULE7
    if (link.port_sel == PORT_INTERNAL && link.pins_persist) begin
      port_ok = 1'b0; // RULE20
    end
  end

  assign link.word_ready = port_ok && state_ff != ST_CHECK;
  assign take            = link.word_valid && link.word_ready;
  assign w_reg           = link.word_data[REGION_LSB +: REGION_W];

  always_comb begin
    nxt_state   = state_ff;
    nxt_kind    = kind_ff;
    nxt_crc     = crc_ff;
    nxt_user    = user_ff;
    nxt_done    = done_ff;
    nxt_err     = err_ff;
    nxt_mask    = MASK_RESET ? '1 : '0; // RULE1
    nxt_clken   = clken_ff;
    nxt_blank   = blank_ff;
    nxt_cleared = cleared_ff;
    nxt_init    = '0;
    nxt_gray    = gray_ff;
    nxt_reg     = reg_ff;
    nxt_gsr     = gsr_req && !user_ff && state_ff != ST_FAIL; // RULE2
    case (state_ff)
      ST_IDLE, ST_USER: begin
        if (take) begin
          nxt_crc = CRC_SEED;
          if (link.word_data == HDR_FULL && !user_ff) begin
            nxt_kind  = KIND_FULL;
            nxt_state = ST_HEAD;
            nxt_done  = 1'b0;
          end else if (user_ff && (link.word_data == HDR_PARTIAL ||
                       link.word_data == HDR_CLEAR ||
                       link.word_data == HDR_BLANK)) begin // RULE5
            nxt_kind  = link.word_data == HDR_PARTIAL ? KIND_PARTIAL :
                        link.word_data == HDR_CLEAR   ? KIND_CLEAR :
                                                        KIND_BLANK;
            nxt_state = ST_HEAD;
            nxt_err   = 1'b0;
            if (link.reset_after_reconfig) begin
              nxt_done = 1'b0; // RULE9 RULE10
            end
          end
        end
      end
      ST_HEAD: begin
        if (take) begin
          nxt_reg   = w_reg;
          nxt_state = ST_DATA;
          if (kind_ff != KIND_FULL) begin
            nxt_blank[w_reg] = kind_ff != KIND_CLEAR; // RULE15
          end
        end
      end
      ST_DATA: begin
        if (kind_ff != KIND_FULL) begin
          nxt_mask[reg_ff] = 1'b1; // RULE1 RULE16
        end
        if (take) begin
          if (link.word_data == DESYNC_WORD) begin
            nxt_state = ST_CHECK; // RULE12
          end else if (link.word_data[31:CRC_MARK_POS] ==
                       CRC_MARK[31:CRC_MARK_POS] &&
                       link.word_data != NOOP_WORD) begin
            if (link.word_data[27:0] != crc_ff[27:0]) begin
              nxt_state = ST_FAIL; // RULE6 RULE8
            end
          end else if (link.word_data != NOOP_WORD) begin
            nxt_crc = crc_step(crc_ff, link.word_data); // RULE6
          end
        end
      end
      ST_CHECK: begin
        case (kind_ff)
          KIND_FULL: begin
            nxt_user  = 1'b1; // RULE4
            nxt_done  = 1'b1;
            nxt_clken = '1;
            nxt_state = ST_USER;
          end
          KIND_CLEAR: begin
            nxt_clken[reg_ff]   = 1'b0; // RULE16
            nxt_cleared[reg_ff] = 1'b1;
            nxt_state           = ST_USER;
          end
          default: begin
            nxt_blank[reg_ff] = 1'b0;
            nxt_gray[reg_ff]  = kind_ff == KIND_BLANK; // RULE14
            nxt_clken[reg_ff] = 1'b1;
            if (cleared_ff[reg_ff] || !NEED_CLEAR) begin
              nxt_init[reg_ff] = 1'b1; // RULE6 RULE17
            end
            nxt_cleared[reg_ff] = 1'b0;
            nxt_done  = 1'b1; // RULE9 RULE10
            nxt_state = ST_USER;
          end
        endcase
        // A failed stream only drains its desync here; nothing else changes.
        if (err_ff) begin
          nxt_user    = user_ff; // RULE3
          nxt_done    = done_ff;
          nxt_clken   = clken_ff;
          nxt_blank   = blank_ff;
          nxt_gray    = gray_ff;
          nxt_cleared = cleared_ff;
          nxt_init    = '0;
          nxt_state   = kind_ff == KIND_FULL ? ST_FAIL : ST_USER;
        end
      end
      ST_FAIL: begin
        nxt_err = 1'b1;
        if (take && link.word_data == DESYNC_WORD) begin
          nxt_state = ST_CHECK; // RULE12
        end
        if (kind_ff == KIND_FULL) begin
          nxt_done = 1'b0; // RULE3
          nxt_user = 1'b0;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff   <= ST_IDLE;
      kind_ff    <= KIND_FULL;
      crc_ff     <= CRC_SEED;
      user_ff    <= 1'b0;
      done_ff    <= 1'b0;
      err_ff     <= 1'b0;
      mask_ff    <= '0;
      clken_ff   <= '0;
      blank_ff   <= '0;
      cleared_ff <= '0;
      init_ff    <= '0;
      gray_ff    <= '0;
      reg_ff     <= '0;
      gsr_ff     <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      kind_ff    <= nxt_kind;
      crc_ff     <= nxt_crc;
      user_ff    <= nxt_user;
      done_ff    <= nxt_done;
      err_ff     <= nxt_err;
      mask_ff    <= nxt_mask;
      clken_ff   <= nxt_clken;
      blank_ff   <= nxt_blank;
      cleared_ff <= nxt_cleared;
      init_ff    <= nxt_init;
      gray_ff    <= nxt_gray;
      reg_ff     <= nxt_reg;
      gsr_ff     <= nxt_gsr;
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  assign link.config_done_flag = done_ff;
  assign link.user_mode        = user_ff;
  assign link.load_error       = err_ff;
  assign region_mask_open      = mask_ff;
  assign region_clk_en         = clken_ff;
  assign region_blanked        = blank_ff | gray_ff;
  assign region_init           = init_ff;
  assign region_ready          = clken_ff & ~blank_ff & ~gray_ff;
  assign blank_outputs         = tieoff_one; // RULE14
  assign gsr_pulse             = gsr_ff;

endmodule

// file: rtl/cfg_link_if.sv
// Link between the reconfiguration controller and the config engine.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface cfg_link_if (input logic clk);
  import cfg_delivery_pkg::*;

  logic        word_valid;
  logic        word_ready;
  logic [31:0] word_data;
  port_sel_t   port_sel;
  logic        pins_persist;
  logic        reset_after_reconfig;
  logic        config_done_flag;
  logic        user_mode;
  logic        load_error;

  modport engine (
    input  word_valid, word_data, port_sel, pins_persist,
           reset_after_reconfig,
    output word_ready, config_done_flag, user_mode, load_error
  );

  modport controller (
    output word_valid, word_data, port_sel, pins_persist,
           reset_after_reconfig,
    input  word_ready, config_done_flag, user_mode, load_error
  );
endinterface
